// ==== bpm_core.sv ====
// power-mode state machine and cell-protection FET control
`timescale 1ns/1ns
`default_nettype none

// Contract
// - after power-up the block starts in active mode.
// - active mode runs measurement and enables FET drive only when safe.
// - sleep stops measurement, disables gate drive and authentication, keeps registers.
// - sleep has two causes, bus-low and undervoltage, each with own enable.
// - charger detect or charge current of 1.6mV blocks sleep entry.
// - sleeping block wakes on charger or rising edge on any bus line.
// - bus-low sleep needs enable and all lines low for sleep timeout.
// - undervoltage sleep needs low cell, enable, and bus static for timeout.
// - undervoltage sleep wakes on any logic change of a bus line.
// - bus-low sleep with wake-switch enable pulls pin high; falling edge wakes.
// - falling edge on programmable pin is debounced 100ms before waking.
// - no wake-switch pull-up or wake when sleep came from undervoltage.
// - protection is evaluated only in active mode, on all sense inputs.
// - overvoltage past its delay turns charge drive off; discharge stays on.
// - overvoltage trip released when both cells fall below charge-enable threshold.
// - overvoltage released early on discharge at 1.2mV with both cells below threshold.
// - undervoltage past its delay turns both drives off; sleeps if enabled.
// - undervoltage released by charger with cells at threshold, or cells high, enable clear.
// - charge overcurrent turns both off; released when pack-plus low with pulldown.
// - discharge overcurrent or short turns discharge off; released pack-plus high with pullup.
// - each drive is high only with no relevant trip and its disable clear.
module bpm_core
    import bpm_pkg::*;
#(
    parameter int SLEEP_CYC = SLEEP_TIMEOUT_CYC,
    parameter int DEBOUNCE_CYC = WAKE_DEBOUNCE_CYC,
    parameter int OV_CYC = OV_DELAY_CYC,
    parameter int UV_CYC = UV_DELAY_CYC,
    parameter int OC_CYC = OC_DELAY_CYC,
    parameter int SC_CYC = SC_DELAY_CYC
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // configuration bits
    input wire logic sleep_on_bus_low_enable_i,
    input wire logic undervoltage_sleep_enable_i,
    input wire logic wake_switch_on_gpio_enable_i,
    input wire logic wake_switch_on_dataline_enable_i,
    input wire logic charge_fet_disable_i,
    input wire logic discharge_fet_disable_i,
    // bus and wake pins (asynchronous)
    input wire logic data_line_i,
    input wire logic clock_line_i,
    input wire logic programmable_io_pin_i,
    // analog comparator flags (asynchronous)
    input wire logic charger_detect_i,
    input wire logic charge_current_min_i,
    input wire logic discharge_current_min_i,
    input wire logic cell_over_ov_i,
    input wire logic cells_below_ov_i,
    input wire logic cells_below_ce_i,
    input wire logic cell_below_uv_i,
    input wire logic cells_above_uv_i,
    input wire logic below_coc_i,
    input wire logic above_doc_i,
    input wire logic above_sc_i,
    input wire logic pack_plus_below_margin_i,
    input wire logic pack_plus_above_margin_i,
    // outputs
    output logic active_o,
    output logic measure_enable_o,
    output logic auth_enable_o,
    output logic charge_fet_drive_o,
    output logic discharge_fet_drive_o,
    output logic pulldown_test_current_o,
    output logic pullup_test_current_o,
    output logic gpio_pullup_o,
    output logic dataline_pullup_o
);
    // ==========================================================
    // input synchronisers
    localparam int NS = 15;
    logic [NS-1:0] raw, s1_q, s2_q;
    assign raw = {data_line_i, clock_line_i, programmable_io_pin_i, charger_detect_i,
        charge_current_min_i, discharge_current_min_i, cell_over_ov_i, cells_below_ov_i,
        cells_below_ce_i, cell_below_uv_i, cells_above_uv_i, below_coc_i, above_doc_i,
        above_sc_i, pack_plus_below_margin_i};
    logic pp_hi_s1_q, pp_hi_q;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            pp_hi_s1_q <= 1'b0;
            pp_hi_q <= 1'b0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            pp_hi_s1_q <= pack_plus_above_margin_i;
            pp_hi_q <= pp_hi_s1_q;
        end
    end
    logic dq, scl, programmable_io_pin, chg, chg_cur, dis_cur, ov, bel_ov, bel_ce, uv, abv_uv, coc, doc, sc, pp_lo;
    assign {dq, scl, programmable_io_pin, chg, chg_cur, dis_cur, ov, bel_ov, bel_ce, uv, abv_uv, coc, doc, sc, pp_lo} = s2_q;

    // ==========================================================
    // qualification counters
    function automatic logic [CNT_W-1:0] qual_next(input logic flag, input logic [CNT_W-1:0] c,
                                                   input int lim);
        if (!flag) qual_next = '0;
        else if (c < CNT_W'(lim)) qual_next = c + 1'b1;
        else qual_next = c;
    endfunction : qual_next

    bpm_mode_t mode_q, mode_d;
    bpm_cause_t cause_q, cause_d;
    logic [CNT_W-1:0] ov_c_q, uv_c_q, coc_c_q, doc_c_q, sc_c_q, bus_c_q, deb_c_q;
    logic [CNT_W-1:0] ov_c_d, uv_c_d, coc_c_d, doc_c_d, sc_c_d, bus_c_d, deb_c_d;
    logic ov_t_q, uv_t_q, coc_t_q, dis_t_q, ov_t_d, uv_t_d, coc_t_d, dis_t_d;
    logic dq_q, scl_q, pio_q, pio_low_q, pio_low_d;
    logic active, bus_low, bus_static, sleep_block, rise, change, pio_fall, wake;

    assign active = (mode_q == BPM_ACTIVE);
    assign bus_low = !dq && !scl;
    assign bus_static = (dq == dq_q) && (scl == scl_q);
    assign sleep_block = chg || chg_cur;
    assign rise = (dq && !dq_q) || (scl && !scl_q);
    assign change = (dq != dq_q) || (scl != scl_q);
    assign pio_fall = !programmable_io_pin && pio_q;

    // ==========================================================
    // protection trips, evaluated only while active
    always_comb begin
        ov_c_d = active ? qual_next(ov, ov_c_q, OV_CYC) : '0;
        uv_c_d = active ? qual_next(uv, uv_c_q, UV_CYC) : '0;
        coc_c_d = active ? qual_next(coc, coc_c_q, OC_CYC) : '0;
        doc_c_d = active ? qual_next(doc, doc_c_q, OC_CYC) : '0;
        sc_c_d = active ? qual_next(sc, sc_c_q, SC_CYC) : '0;
        ov_t_d = ov_t_q;
        uv_t_d = uv_t_q;
        coc_t_d = coc_t_q;
        dis_t_d = dis_t_q;
        if (active) begin
            if (ov_c_q >= CNT_W'(OV_CYC)) ov_t_d = 1'b1;
            else if (bel_ce || (dis_cur && bel_ov)) ov_t_d = 1'b0;
            if (uv_c_q >= CNT_W'(UV_CYC)) uv_t_d = 1'b1;
            else if (abv_uv && (chg || !undervoltage_sleep_enable_i)) uv_t_d = 1'b0;
            if (coc_c_q >= CNT_W'(OC_CYC)) coc_t_d = 1'b1;
            else if (pp_lo) coc_t_d = 1'b0;
            if (doc_c_q >= CNT_W'(OC_CYC) || sc_c_q >= CNT_W'(SC_CYC)) dis_t_d = 1'b1;
            else if (pp_hi_q) dis_t_d = 1'b0;
        end
    end

    // ==========================================================
    // power-mode machine
    always_comb begin
        mode_d = mode_q;
        cause_d = cause_q;
        bus_c_d = '0;
        deb_c_d = '0;
        pio_low_d = 1'b0;
        wake = 1'b0;
        if (active) begin
            if (sleep_on_bus_low_enable_i) bus_c_d = qual_next(bus_low, bus_c_q, SLEEP_CYC);
            else if (undervoltage_sleep_enable_i) bus_c_d = qual_next(bus_static, bus_c_q, SLEEP_CYC);
            if (!sleep_block && bus_c_q >= CNT_W'(SLEEP_CYC)) begin
                if (sleep_on_bus_low_enable_i && bus_low) begin
                    mode_d = BPM_SLEEP;
                    cause_d = BPM_CAUSE_BUS;
                end
            end
            if (!sleep_block && undervoltage_sleep_enable_i && uv_t_q && bus_static
                && qual_next(bus_static, bus_c_q, SLEEP_CYC) >= CNT_W'(SLEEP_CYC)) begin
                mode_d = BPM_SLEEP;
                cause_d = BPM_CAUSE_UV;
            end
        end else begin
            // debounce a low on the wake pin after its falling edge
            pio_low_d = pio_low_q ? !programmable_io_pin : pio_fall;
            deb_c_d = pio_low_q ? qual_next(!programmable_io_pin, deb_c_q, DEBOUNCE_CYC) : '0;
            if (chg || rise) wake = 1'b1;
            if (cause_q == BPM_CAUSE_UV && change) wake = 1'b1;
            if (cause_q == BPM_CAUSE_BUS) begin
                if (wake_switch_on_gpio_enable_i && pio_low_q && deb_c_q >= CNT_W'(DEBOUNCE_CYC))
                    wake = 1'b1;
                if (wake_switch_on_dataline_enable_i && !dq && dq_q) wake = 1'b1;
            end
            if (wake) begin
                mode_d = BPM_ACTIVE;
                cause_d = BPM_CAUSE_NONE;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mode_q <= BPM_ACTIVE;
            cause_q <= BPM_CAUSE_NONE;
            {ov_c_q, uv_c_q, coc_c_q, doc_c_q, sc_c_q, bus_c_q, deb_c_q} <= '0;
            {ov_t_q, uv_t_q, coc_t_q, dis_t_q} <= '0;
            {dq_q, scl_q, pio_q, pio_low_q} <= 4'h0;
        end else begin
            mode_q <= mode_d;
            cause_q <= cause_d;
            {ov_c_q, uv_c_q, coc_c_q, doc_c_q, sc_c_q, bus_c_q, deb_c_q} <=
                {ov_c_d, uv_c_d, coc_c_d, doc_c_d, sc_c_d, bus_c_d, deb_c_d};
            {ov_t_q, uv_t_q, coc_t_q, dis_t_q} <= {ov_t_d, uv_t_d, coc_t_d, dis_t_d};
            {dq_q, scl_q, pio_q, pio_low_q} <= {dq, scl, programmable_io_pin, pio_low_d};
        end
    end

    // ==========================================================
    // outputs; trip flags persist through sleep so state is retained
    assign active_o = active;
    assign measure_enable_o = active;
    assign auth_enable_o = active;
    assign charge_fet_drive_o = active && !ov_t_q && !uv_t_q && !coc_t_q && !charge_fet_disable_i;
    assign discharge_fet_drive_o = active && !uv_t_q && !coc_t_q && !dis_t_q && !discharge_fet_disable_i;
    assign pulldown_test_current_o = active && coc_t_q;
    assign pullup_test_current_o = active && dis_t_q;
    assign gpio_pullup_o = !active && cause_q == BPM_CAUSE_BUS && wake_switch_on_gpio_enable_i;
    assign dataline_pullup_o = !active && cause_q == BPM_CAUSE_BUS && wake_switch_on_dataline_enable_i;

    // ==========================================================
    // assertions
    AST_RESET_ACTIVE: assert property (@(posedge clock_i) $fell(rst_i) |-> active_o)
        else $error("not active after reset");
    AST_SLEEP_NO_DRIVE: assert property (@(posedge clock_i) disable iff (rst_i)
        !active_o |-> !charge_fet_drive_o && !discharge_fet_drive_o && !measure_enable_o)
        else $error("drive during sleep");
    AST_NO_SLEEP_CHARGER: assert property (@(posedge clock_i) disable iff (rst_i)
        active && sleep_block |=> active)
        else $error("slept with charger");
    AST_CHARGER_WAKE: assert property (@(posedge clock_i) disable iff (rst_i)
        !active && chg |=> active)
        else $error("no wake on charger");
    AST_UV_NO_SWITCH: assert property (@(posedge clock_i) disable iff (rst_i)
        cause_q == BPM_CAUSE_UV |-> !gpio_pullup_o && !dataline_pullup_o)
        else $error("pullup in uv sleep");
    AST_OV_DC_KEEP: assert property (@(posedge clock_i) disable iff (rst_i)
        ov_t_q && !uv_t_q && !coc_t_q && !dis_t_q && active && !discharge_fet_disable_i
        |-> !charge_fet_drive_o && discharge_fet_drive_o)
        else $error("ov response wrong");
    AST_OV_RELEASE: assert property (@(posedge clock_i) disable iff (rst_i)
        active && ov_t_q && bel_ce && ov_c_q < CNT_W'(OV_CYC) |=> !ov_t_q)
        else $error("ov not released");
    AST_SC_TRIP: assert property (@(posedge clock_i) disable iff (rst_i)
        active && sc_c_q >= CNT_W'(SC_CYC) |=> !discharge_fet_drive_o)
        else $error("short not tripped");
    AST_CC_DISABLE: assert property (@(posedge clock_i) disable iff (rst_i)
        charge_fet_disable_i |-> !charge_fet_drive_o)
        else $error("charge drive while disabled");
    AST_CNT_RESTART: assert property (@(posedge clock_i) disable iff (rst_i)
        !ov |=> ov_c_q == '0)
        else $error("counter not restarted");
    COV_BUS_SLEEP: cover property (@(posedge clock_i) cause_q == BPM_CAUSE_BUS);
    COV_UV_SLEEP: cover property (@(posedge clock_i) cause_q == BPM_CAUSE_UV);
    COV_WAKE: cover property (@(posedge clock_i) $rose(active));
    COV_DIS_TRIP: cover property (@(posedge clock_i) $rose(dis_t_q));
endmodule : bpm_core

`default_nettype wire

// ==== bpm_pkg.sv ====
// package: constants for the battery power-mode and protection block
package bpm_pkg;
    // clock rate and timing figures
    localparam int CLK_HZ = 20_000_000;
    localparam int WAKE_DEBOUNCE_MS = 100;
    localparam int WAKE_DEBOUNCE_CYC = WAKE_DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int SLEEP_TIMEOUT_MS = 2000;
    localparam int SLEEP_TIMEOUT_CYC = SLEEP_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int OV_DELAY_MS = 1000;
    localparam int OV_DELAY_CYC = OV_DELAY_MS * (CLK_HZ / 1000);
    localparam int UV_DELAY_MS = 100;
    localparam int UV_DELAY_CYC = UV_DELAY_MS * (CLK_HZ / 1000);
    localparam int OC_DELAY_MS = 10;
    localparam int OC_DELAY_CYC = OC_DELAY_MS * (CLK_HZ / 1000);
    localparam int SC_DELAY_US = 100;
    localparam int SC_DELAY_CYC = SC_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 32;

    typedef enum logic [0:0] {
        BPM_ACTIVE = 1'b0,
        BPM_SLEEP = 1'b1
    } bpm_mode_t;

    typedef enum logic [1:0] {
        BPM_CAUSE_NONE = 2'b00,
        BPM_CAUSE_BUS = 2'b01,
        BPM_CAUSE_UV = 2'b10
    } bpm_cause_t;
endpackage : bpm_pkg

// ==== bpm_far_model.sv ====
// far-side model: host bus lines, wake switch, charger and load on the pack terminal
`timescale 1ns/1ns
`default_nettype none
module bpm_far_model (
    // bench stimulus
    input wire logic bus_high_i,
    input wire logic switch_closed_i,
    input wire logic charger_i,
    input wire logic load_i,
    // test currents from the block
    input wire logic pulldown_test_current_i,
    input wire logic pullup_test_current_i,
    // lines into the block
    output logic data_line_o,
    output logic clock_line_o,
    output logic programmable_io_pin_o,
    output logic charger_detect_o,
    output logic pack_plus_below_margin_o,
    output logic pack_plus_above_margin_o
);
    // host powered down leaves both lines low together
    assign data_line_o = bus_high_i;
    assign clock_line_o = bus_high_i;
    // dry contact to ground, otherwise the pin pull-up wins
    assign programmable_io_pin_o = ~switch_closed_i;
    assign charger_detect_o = charger_i;
    // pack plus only sags below the margin once the charger is gone
    assign pack_plus_below_margin_o = pulldown_test_current_i & ~charger_i;
    assign pack_plus_above_margin_o = pullup_test_current_i & ~load_i;
endmodule : bpm_far_model
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the power-mode and protection block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import bpm_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic bl_en = 1'b0, uv_en = 1'b0, gp_en = 1'b0, dl_en = 1'b0, cd = 1'b0, dd = 1'b0;
    logic bus_hi = 1'b1, sw = 1'b0, chg = 1'b0, load = 1'b1, chg_min = 1'b0, dis_min = 1'b0;
    logic ov = 1'b0, bov = 1'b1, bce = 1'b1, uv = 1'b0, auv = 1'b1, coc = 1'b0, doc = 1'b0, sc = 1'b0;
    logic dl, cl, programmable_io_pin, chg_det, ppb, ppa, act, meas, auth, cfd, dfd, pd, pu, gpu, dpu;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    always #25 clock_i = ~clock_i;
    bpm_far_model far_u (.bus_high_i(bus_hi), .switch_closed_i(sw), .charger_i(chg), .load_i(load),
        .pulldown_test_current_i(pd), .pullup_test_current_i(pu), .data_line_o(dl), .clock_line_o(cl),
        .programmable_io_pin_o(programmable_io_pin), .charger_detect_o(chg_det), .pack_plus_below_margin_o(ppb),
        .pack_plus_above_margin_o(ppa));
    bpm_core #(.SLEEP_CYC(20), .DEBOUNCE_CYC(10), .OV_CYC(8), .UV_CYC(8), .OC_CYC(4), .SC_CYC(2)) dut_u (
        .clock_i(clock_i), .rst_i(rst_i), .sleep_on_bus_low_enable_i(bl_en), .undervoltage_sleep_enable_i(uv_en),
        .wake_switch_on_gpio_enable_i(gp_en), .wake_switch_on_dataline_enable_i(dl_en),
        .charge_fet_disable_i(cd), .discharge_fet_disable_i(dd), .data_line_i(dl), .clock_line_i(cl),
        .programmable_io_pin_i(programmable_io_pin), .charger_detect_i(chg_det), .charge_current_min_i(chg_min),
        .discharge_current_min_i(dis_min), .cell_over_ov_i(ov), .cells_below_ov_i(bov), .cells_below_ce_i(bce),
        .cell_below_uv_i(uv), .cells_above_uv_i(auv), .below_coc_i(coc), .above_doc_i(doc), .above_sc_i(sc),
        .pack_plus_below_margin_i(ppb), .pack_plus_above_margin_i(ppa), .active_o(act),
        .measure_enable_o(meas), .auth_enable_o(auth), .charge_fet_drive_o(cfd), .discharge_fet_drive_o(dfd),
        .pulldown_test_current_o(pd), .pullup_test_current_o(pu), .gpio_pullup_o(gpu), .dataline_pullup_o(dpu));
    // ==========================================
    // shared tasks
    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask : tick
    task automatic check(input logic got, input logic exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    task automatic print_verdict();
        if (err_total == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    // ==========================================
    // scenarios
    task automatic t_reset();
        check(act, 1'b1, "not active after reset");
        check(cfd & dfd, 1'b1, "drives off after reset");
        cd = 1'b1;
        tick(2);
        check(cfd, 1'b0, "charge drive ignores disable");
        cd = 1'b0;
        dd = 1'b1;
        tick(2);
        check(dfd, 1'b0, "discharge drive ignores disable");
        dd = 1'b0;
    endtask : t_reset
    task automatic t_overvoltage();
        ov = 1'b1; bov = 1'b0; bce = 1'b0;
        tick(5);
        ov = 1'b0;
        tick(1);
        ov = 1'b1;
        tick(6);
        check(cfd, 1'b1, "delay count not restarted");
        tick(10);
        check(cfd, 1'b0, "overvoltage trip missing");
        check(dfd, 1'b1, "discharge cut on overvoltage");
        ov = 1'b0; bov = 1'b1;
        tick(6);
        check(cfd, 1'b0, "overvoltage released too early");
        dis_min = 1'b1;
        tick(5);
        check(cfd, 1'b1, "no early release on discharge");
        dis_min = 1'b0; ov = 1'b1; bov = 1'b0;
        tick(16);
        ov = 1'b0; bov = 1'b1; bce = 1'b1;
        tick(5);
        check(cfd, 1'b1, "no release below charge enable");
    endtask : t_overvoltage
    task automatic t_current();
        sc = 1'b1;
        tick(8);
        sc = 1'b0;
        check(dfd, 1'b0, "short circuit response");
        check(cfd & pu, 1'b1, "short circuit charge drive or pull-up");
        load = 1'b0;
        tick(5);
        check(dfd, 1'b1, "short circuit release");
        check(pu, 1'b0, "pull-up left on after release");
        load = 1'b1; doc = 1'b1;
        tick(10);
        doc = 1'b0;
        check(dfd, 1'b0, "discharge overcurrent trip missing");
        load = 1'b0;
        tick(5);
        check(dfd, 1'b1, "discharge overcurrent release");
        load = 1'b1; chg = 1'b1; coc = 1'b1;
        tick(10);
        coc = 1'b0;
        check(cfd | dfd | ~pd, 1'b0, "charge overcurrent response");
        chg = 1'b0;
        tick(5);
        check(cfd & dfd & ~pd, 1'b1, "charge overcurrent release");
    endtask : t_current
    task automatic t_bus_sleep();
        bl_en = 1'b1; gp_en = 1'b1; dl_en = 1'b1; bus_hi = 1'b0;
        tick(10);
        check(act, 1'b1, "sleep before timeout");
        tick(25);
        check(act | meas | auth | cfd | dfd, 1'b0, "bus-low sleep state");
        check(gpu & dpu, 1'b1, "wake pull-ups missing");
        sw = 1'b1;
        tick(4);
        sw = 1'b0;
        tick(20);
        check(act, 1'b0, "glitch woke the block");
        sw = 1'b1;
        tick(20);
        check(act, 1'b1, "switch did not wake");
        sw = 1'b0; bus_hi = 1'b1; chg = 1'b1;
        tick(3);
        bus_hi = 1'b0;
        tick(40);
        check(act, 1'b1, "sleep with charger present");
        chg = 1'b0; chg_min = 1'b1;
        tick(40);
        check(act, 1'b1, "sleep with charge current");
        chg_min = 1'b0;
        tick(35);
        check(act, 1'b0, "no sleep once block removed");
        bus_hi = 1'b1;
        tick(5);
        check(act, 1'b1, "rising line did not wake");
        bus_hi = 1'b0;
        tick(35);
        check(act, 1'b0, "no sleep before charger wake");
        chg = 1'b1;
        tick(5);
        check(act, 1'b1, "charger did not wake");
        chg = 1'b0; bus_hi = 1'b1; bl_en = 1'b0;
    endtask : t_bus_sleep
    task automatic t_undervoltage();
        uv_en = 1'b1; uv = 1'b1; auv = 1'b0;
        tick(14);
        check(cfd | dfd, 1'b0, "undervoltage trip missing");
        tick(30);
        check(act | gpu | dpu, 1'b0, "undervoltage sleep state");
        bus_hi = 1'b0;
        tick(5);
        check(act, 1'b1, "line change did not wake");
        chg = 1'b1;
        tick(6);
        check(cfd, 1'b0, "release with cell still low");
        uv = 1'b0; auv = 1'b1;
        tick(6);
        check(cfd & dfd, 1'b1, "charger release missing");
        chg = 1'b0; uv_en = 1'b0; uv = 1'b1; auv = 1'b0; bus_hi = 1'b1;
        tick(14);
        uv = 1'b0; auv = 1'b1;
        tick(6);
        check(dfd & act, 1'b1, "release with enable clear");
    endtask : t_undervoltage
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        tick(8);
        rst_i = 1'b0;
        tick(1);
        t_reset();
        t_overvoltage();
        t_current();
        t_bus_sleep();
        t_undervoltage();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
